/* File: spts_consts.svh */
// Register offsets, field positions and reset values of the SPI target semaphore block
`ifndef SPTS_CONSTS_SVH
`define SPTS_CONSTS_SVH
`define SPTS_OFF_ACQ_TASK 12'h024
`define SPTS_OFF_REL_TASK 12'h028
`define SPTS_OFF_ACQ_SUB 12'h0a4
`define SPTS_OFF_REL_SUB 12'h0a8
`define SPTS_OFF_EV_END 12'h104
`define SPTS_OFF_EV_RXFULL 12'h110
`define SPTS_OFF_EV_ACQ 12'h128
`define SPTS_OFF_PUB_END 12'h184
`define SPTS_OFF_PUB_RXFULL 12'h190
`define SPTS_OFF_PUB_ACQ 12'h1a8
`define SPTS_OFF_EVENT_TASK_SHORTCUTS 12'h200
`define SPTS_OFF_IRQ_SET 12'h304
`define SPTS_OFF_IRQ_CLR 12'h308
`define SPTS_OFF_SEMSTATE 12'h400
`define SPTS_OFF_STATUS 12'h440
`define SPTS_OFF_ENABLE 12'h500
`define SPTS_OFF_PIN_SCK 12'h508
`define SPTS_OFF_PIN_OUT 12'h50c
`define SPTS_OFF_PIN_IN 12'h510
`define SPTS_OFF_PIN_CS 12'h514
`define SPTS_OFF_RX_CNT 12'h530
`define SPTS_OFF_RX_PTR 12'h534
`define SPTS_OFF_RX_LIM 12'h538
`define SPTS_OFF_RX_LIST 12'h540
`define SPTS_OFF_TX_PTR 12'h544
`define SPTS_OFF_TX_LIM 12'h548
`define SPTS_OFF_TX_CNT 12'h54c
`define SPTS_OFF_TX_LIST 12'h550
`define SPTS_OFF_CONFIG 12'h554
`define SPTS_OFF_DEF_CHAR 12'h55c
`define SPTS_OFF_ORC_CHAR 12'h5c0
`define SPTS_ENABLE_VAL 4'h2
`define SPTS_SUB_EN_BIT 31
`define SPTS_SHORT_END_ACQ_BIT 2
`define SPTS_IRQ_END_BIT 1
`define SPTS_IRQ_RXFULL_BIT 4
`define SPTS_IRQ_ACQ_BIT 10
`define SPTS_ST_TX_EXCESS_FLAG_BIT 0
`define SPTS_ST_OVERFLOW_BIT 1
`define SPTS_PIN_RESET 32'hffffffff
`define SPTS_BITS_PER_BYTE 3'h7
`endif

/* File: spts_pkg.sv */
// Types shared by the SPI target semaphore block
package spts_pkg;
   typedef enum logic [3:0] {
      SPTS_SEM_FREE = 4'b0001,
      SPTS_SEM_CPU = 4'b0010,
      SPTS_SEM_TGT = 4'b0100,
      SPTS_SEM_TGT_PEND = 4'b1000
   } spts_sem_t;
   typedef struct packed {
      logic valid;
      logic [7:0] chan;
   } spts_evch_t;
   typedef struct packed {
      logic en;
      logic [7:0] chan;
   } spts_chcfg_t;
endpackage : spts_pkg

/* File: spts_top.sv */
// SPI target register block with buffer semaphore, byte engine and event routing
// Function
// RULE_01: Release task returns the semaphore from the CPU so the target may take it.
// RULE_02: Programmable default character is shifted out during ignored transactions.
// RULE_03: Receive byte count of the last granted transaction is readable.
// RULE_04: Transmit byte count of the last granted transaction is readable.
// RULE_05: Receive limit and receive buffer pointer registers exist.
// RULE_06: Transmit limit and transmit buffer pointer registers exist.
// RULE_07: Acquire and release tasks can subscribe to a selectable event channel.
// RULE_08: End, receive-full and acquired events publish onto configurable channels.
// RULE_09: Shortcut register lets the end event fire the acquire task.
// RULE_10: Status register records errors of the last transaction.
// RULE_11: Enable gives the CPU the semaphore silently; acquire while holding signals at once.
// RULE_12: Select low tries the semaphore; CPU holding means ignore; ties go to CPU.
// RULE_13: Granted end releases semaphore, raises end; one pending acquire then served.
// RULE_14: Excess received bytes dropped with overflow; excess reads send over-read character.
// RULE_15: Acquire task register is write-one trigger that reads back zero.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "spts_consts.svh"
`default_nettype none
module spts_top (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sck_i,
   input wire logic cs_b_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic rx_wr_o,
   output logic [31:0] rx_wr_addr_o,
   output logic [7:0] rx_wr_data_o,
   output logic [31:0] tx_rd_addr_o,
   input wire logic [7:0] tx_rd_data_i,
   input wire spts_pkg::spts_evch_t sub_i,
   output spts_pkg::spts_evch_t pub_end_o,
   output spts_pkg::spts_evch_t pub_rxfull_o,
   output spts_pkg::spts_evch_t pub_acq_o,
   output logic irq_o
);
   import spts_pkg::*;
   spts_sem_t sem;
   spts_chcfg_t acq_sub, rel_sub, end_pub, rxf_pub, acq_pub;
   logic [2:0] ev, inten, sck_s, cs_s;
   logic [1:0] status, mosi_s;
   logic short_end_acq, enable, enable_q, active, granted, ignored;
   logic [31:0] rx_ptr, tx_ptr, pin_sck, pin_out, pin_in, pin_cs;
   logic [15:0] rx_lim, tx_lim, rx_cnt, tx_cnt, rx_amt, tx_amt;
   logic [2:0] cfg;
   logic [1:0] rx_list, tx_list;
   logic [7:0] def_char, orc_char, rx_sh, tx_sh;
   logic [2:0] bitcnt;
   logic [31:0] rd_mux;
   logic map_hit;
   // Bus phases: one wait state, answer registered so outputs come from flops
   wire acc = psel_i & penable_i & ~pready_o;
   wire fire = psel_i & penable_i & pready_o;
   wire wr = fire & pwrite_i;
   wire [11:0] a = paddr_i;
   wire w0 = pwdata_i[0];
   // Synchronised SPI pins, edges seen between the second and third stage
   wire sck_rise = sck_s[1] & ~sck_s[2];
   wire sck_fall = ~sck_s[1] & sck_s[2];
   wire cs_fall = ~cs_s[1] & cs_s[2] & enable;
   wire cs_rise = cs_s[1] & ~cs_s[2];
   wire byte_done = active & sck_rise & (bitcnt == `SPTS_BITS_PER_BYTE);
   wire [7:0] rx_byte = {rx_sh[6:0], mosi_s[1]};
   // Task triggers from register writes and subscribed channels
   wire sub_acq = sub_i.valid & acq_sub.en & (sub_i.chan == acq_sub.chan); // RULE_07
   wire sub_rel = sub_i.valid & rel_sub.en & (sub_i.chan == rel_sub.chan); // RULE_07
   wire acq_task = ((wr & (a == `SPTS_OFF_ACQ_TASK) & w0) | sub_acq) & enable; // RULE_15
   wire rel_task = ((wr & (a == `SPTS_OFF_REL_TASK) & w0) | sub_rel) & enable; // RULE_01
   // A select edge only wins a free semaphore when the CPU is not asking too
   wire grant_now = cs_fall & (sem == SPTS_SEM_FREE) & ~acq_task; // RULE_12
   wire end_now = cs_rise & active & granted; // RULE_13
   wire rx_room = rx_cnt < rx_lim;
   wire tx_room = tx_cnt < tx_lim;
   wire rx_store = byte_done & granted & rx_room;
   wire rx_full_now = rx_store & (rx_cnt + 16'h0001 == rx_lim);
   wire ovf_now = byte_done & granted & ~rx_room; // RULE_14
   wire load_next = active & sck_fall & (bitcnt == 3'h0);
   wire tx_take = (grant_now | (load_next & granted)) & tx_room;
   wire ovr_now = (grant_now | (load_next & granted)) & ~tx_room; // RULE_14
   wire [7:0] tx_next = ignored ? def_char : (tx_room ? tx_rd_data_i : orc_char);
   wire acq_ev_now;
   wire [2:0] ev_set = {acq_ev_now, rx_full_now, end_now};
   wire [2:0] ev_wr = {wr & (a == `SPTS_OFF_EV_ACQ), wr & (a == `SPTS_OFF_EV_RXFULL),
      wr & (a == `SPTS_OFF_EV_END)};
   wire [2:0] irq_bits = {pwdata_i[`SPTS_IRQ_ACQ_BIT], pwdata_i[`SPTS_IRQ_RXFULL_BIT],
      pwdata_i[`SPTS_IRQ_END_BIT]};
   spts_sem_t next_sem;
   logic next_acq_ev;
   always_comb
   begin
      next_sem = sem;
      next_acq_ev = 1'b0;
      if (enable & ~enable_q)
         next_sem = SPTS_SEM_CPU; // RULE_11
      else if (~enable)
         next_sem = SPTS_SEM_FREE;
      else
         case (sem)
            SPTS_SEM_FREE:
            begin
               if (acq_task)
               begin
                  next_sem = SPTS_SEM_CPU;
                  next_acq_ev = 1'b1;
               end
               else if (grant_now)
                  next_sem = SPTS_SEM_TGT; // RULE_12
            end
            SPTS_SEM_CPU:
            begin
               if (rel_task)
                  next_sem = SPTS_SEM_FREE; // RULE_01
               else if (acq_task)
                  next_acq_ev = 1'b1; // RULE_11
            end
            SPTS_SEM_TGT:
            begin
               if (end_now & (acq_task | short_end_acq))
               begin
                  next_sem = SPTS_SEM_CPU; // RULE_09
                  next_acq_ev = 1'b1;
               end
               else if (end_now)
                  next_sem = SPTS_SEM_FREE; // RULE_13
               else if (acq_task)
                  next_sem = SPTS_SEM_TGT_PEND;
            end
            SPTS_SEM_TGT_PEND:
            begin
               // Several requests during the transaction collapse to one handover
               if (end_now)
               begin
                  next_sem = SPTS_SEM_CPU; // RULE_13
                  next_acq_ev = 1'b1;
               end
            end
            default: next_sem = SPTS_SEM_FREE;
         endcase
   end
   assign acq_ev_now = next_acq_ev;
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sem <= SPTS_SEM_FREE;
         enable_q <= 1'b0;
      end
      else
      begin
         sem <= next_sem;
         enable_q <= enable;
      end
   end
   // Pin synchronisers
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sck_s <= 3'h0;
         cs_s <= 3'h7;
         mosi_s <= 2'h0;
      end
      else
      begin
         sck_s <= {sck_s[1:0], sck_i};
         cs_s <= {cs_s[1:0], cs_b_i};
         mosi_s <= {mosi_s[0], mosi_i};
      end
   end
   // Byte engine, mode 0, most significant bit first
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         active <= 1'b0;
         granted <= 1'b0;
         ignored <= 1'b0;
         bitcnt <= 3'h0;
         rx_sh <= 8'h00;
         tx_sh <= 8'h00;
         rx_cnt <= 16'h0000;
         tx_cnt <= 16'h0000;
         rx_amt <= 16'h0000;
         tx_amt <= 16'h0000;
         rx_wr_o <= 1'b0;
         rx_wr_addr_o <= 32'h00000000;
         rx_wr_data_o <= 8'h00;
         tx_rd_addr_o <= 32'h00000000;
      end
      else
      begin
         rx_wr_o <= rx_store;
         // Count is stale between frames, so the first byte comes from the pointer itself
         tx_rd_addr_o <= tx_ptr + {16'h0000, active ? tx_cnt : 16'h0000}; // RULE_06
         if (cs_fall)
         begin
            active <= 1'b1;
            granted <= grant_now;
            ignored <= ~grant_now; // RULE_12
            bitcnt <= 3'h0;
            rx_cnt <= 16'h0000;
            tx_cnt <= {15'h0000, grant_now & tx_room};
            tx_sh <= grant_now ? (tx_room ? tx_rd_data_i : orc_char) : def_char; // RULE_02
         end
         else if (cs_rise | ~enable)
         begin
            active <= 1'b0;
            granted <= 1'b0;
            ignored <= 1'b0;
            if (end_now)
            begin
               rx_amt <= rx_cnt; // RULE_03
               tx_amt <= tx_cnt; // RULE_04
            end
         end
         else if (active)
         begin
            if (sck_rise)
            begin
               bitcnt <= bitcnt + 3'h1;
               rx_sh <= rx_byte;
            end
            if (sck_fall)
               tx_sh <= (bitcnt == 3'h0) ? tx_next : {tx_sh[6:0], 1'b0}; // RULE_02
            if (rx_store)
            begin
               rx_cnt <= rx_cnt + 16'h0001; // RULE_05
               rx_wr_addr_o <= rx_ptr + {16'h0000, rx_cnt};
               rx_wr_data_o <= rx_byte;
            end
            if (tx_take)
               tx_cnt <= tx_cnt + 16'h0001; // RULE_06
         end
      end
   end
   assign miso_o = tx_sh[7];
   assign miso_oe_o = active;
   // Register file
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         acq_sub <= '0;
         rel_sub <= '0;
         end_pub <= '0;
         rxf_pub <= '0;
         acq_pub <= '0;
         short_end_acq <= 1'b0;
         inten <= 3'h0;
         ev <= 3'h0;
         status <= 2'h0;
         enable <= 1'b0;
         pin_sck <= `SPTS_PIN_RESET;
         pin_out <= `SPTS_PIN_RESET;
         pin_in <= `SPTS_PIN_RESET;
         pin_cs <= `SPTS_PIN_RESET;
         rx_ptr <= 32'h00000000;
         tx_ptr <= 32'h00000000;
         rx_lim <= 16'h0000;
         tx_lim <= 16'h0000;
         rx_list <= 2'h0;
         tx_list <= 2'h0;
         cfg <= 3'h0;
         def_char <= 8'h00;
         orc_char <= 8'h00;
      end
      else
      begin
         // Hardware set wins over a software clear in the same cycle
         ev <= (ev & ~(ev_wr & {3{w0}})) | ev_set;
         status <= (status & ~({2{wr & (a == `SPTS_OFF_STATUS)}} & pwdata_i[1:0]))
            | {ovf_now, ovr_now}; // RULE_10
         if (wr)
         begin
            if (a == `SPTS_OFF_ACQ_SUB)
               acq_sub <= {pwdata_i[`SPTS_SUB_EN_BIT], pwdata_i[7:0]}; // RULE_07
            else if (a == `SPTS_OFF_REL_SUB)
               rel_sub <= {pwdata_i[`SPTS_SUB_EN_BIT], pwdata_i[7:0]}; // RULE_07
            else if (a == `SPTS_OFF_PUB_END)
               end_pub <= {pwdata_i[`SPTS_SUB_EN_BIT], pwdata_i[7:0]}; // RULE_08
            else if (a == `SPTS_OFF_PUB_RXFULL)
               rxf_pub <= {pwdata_i[`SPTS_SUB_EN_BIT], pwdata_i[7:0]}; // RULE_08
            else if (a == `SPTS_OFF_PUB_ACQ)
               acq_pub <= {pwdata_i[`SPTS_SUB_EN_BIT], pwdata_i[7:0]}; // RULE_08
            else if (a == `SPTS_OFF_EVENT_TASK_SHORTCUTS)
               short_end_acq <= pwdata_i[`SPTS_SHORT_END_ACQ_BIT]; // RULE_09
            else if (a == `SPTS_OFF_IRQ_SET)
               inten <= inten | irq_bits;
            else if (a == `SPTS_OFF_IRQ_CLR)
               inten <= inten & ~irq_bits;
            else if (a == `SPTS_OFF_ENABLE)
               enable <= (pwdata_i[3:0] == `SPTS_ENABLE_VAL);
            // Pin selects only matter while disabled, so they are not write-locked
            else if (a == `SPTS_OFF_PIN_SCK)
               pin_sck <= pwdata_i;
            else if (a == `SPTS_OFF_PIN_OUT)
               pin_out <= pwdata_i;
            else if (a == `SPTS_OFF_PIN_IN)
               pin_in <= pwdata_i;
            else if (a == `SPTS_OFF_PIN_CS)
               pin_cs <= pwdata_i;
            else if (a == `SPTS_OFF_RX_PTR)
               rx_ptr <= pwdata_i; // RULE_05
            else if (a == `SPTS_OFF_RX_LIM)
               rx_lim <= pwdata_i[15:0]; // RULE_05
            else if (a == `SPTS_OFF_RX_LIST)
               rx_list <= pwdata_i[1:0];
            else if (a == `SPTS_OFF_TX_PTR)
               tx_ptr <= pwdata_i; // RULE_06
            else if (a == `SPTS_OFF_TX_LIM)
               tx_lim <= pwdata_i[15:0]; // RULE_06
            else if (a == `SPTS_OFF_TX_LIST)
               tx_list <= pwdata_i[1:0];
            else if (a == `SPTS_OFF_CONFIG)
               cfg <= pwdata_i[2:0];
            else if (a == `SPTS_OFF_DEF_CHAR)
               def_char <= pwdata_i[7:0]; // RULE_02
            else if (a == `SPTS_OFF_ORC_CHAR)
               orc_char <= pwdata_i[7:0]; // RULE_14
         end
      end
   end
   // Read decode; task registers are decoded but read back zero
   always_comb
   begin
      rd_mux = 32'h00000000;
      map_hit = 1'b1;
      if (a == `SPTS_OFF_ACQ_TASK || a == `SPTS_OFF_REL_TASK)
         rd_mux = 32'h00000000; // RULE_15
      else if (a == `SPTS_OFF_ACQ_SUB)
         rd_mux = {acq_sub.en, 23'h000000, acq_sub.chan};
      else if (a == `SPTS_OFF_REL_SUB)
         rd_mux = {rel_sub.en, 23'h000000, rel_sub.chan};
      else if (a == `SPTS_OFF_EV_END)
         rd_mux = {31'h00000000, ev[0]};
      else if (a == `SPTS_OFF_EV_RXFULL)
         rd_mux = {31'h00000000, ev[1]};
      else if (a == `SPTS_OFF_EV_ACQ)
         rd_mux = {31'h00000000, ev[2]};
      else if (a == `SPTS_OFF_PUB_END)
         rd_mux = {end_pub.en, 23'h000000, end_pub.chan};
      else if (a == `SPTS_OFF_PUB_RXFULL)
         rd_mux = {rxf_pub.en, 23'h000000, rxf_pub.chan};
      else if (a == `SPTS_OFF_PUB_ACQ)
         rd_mux = {acq_pub.en, 23'h000000, acq_pub.chan};
      else if (a == `SPTS_OFF_EVENT_TASK_SHORTCUTS)
         rd_mux = {29'h00000000, short_end_acq, 2'h0};
      else if (a == `SPTS_OFF_IRQ_SET || a == `SPTS_OFF_IRQ_CLR)
         rd_mux = {21'h000000, inten[2], 5'h00, inten[1], 2'h0, inten[0], 1'b0};
      else if (a == `SPTS_OFF_SEMSTATE)
         rd_mux = {28'h0000000, sem};
      else if (a == `SPTS_OFF_STATUS)
         rd_mux = {30'h00000000, status}; // RULE_10
      else if (a == `SPTS_OFF_ENABLE)
         rd_mux = enable ? {28'h0000000, `SPTS_ENABLE_VAL} : 32'h00000000;
      else if (a == `SPTS_OFF_PIN_SCK)
         rd_mux = pin_sck;
      else if (a == `SPTS_OFF_PIN_OUT)
         rd_mux = pin_out;
      else if (a == `SPTS_OFF_PIN_IN)
         rd_mux = pin_in;
      else if (a == `SPTS_OFF_PIN_CS)
         rd_mux = pin_cs;
      else if (a == `SPTS_OFF_RX_CNT)
         rd_mux = {16'h0000, rx_amt}; // RULE_03
      else if (a == `SPTS_OFF_RX_PTR)
         rd_mux = rx_ptr;
      else if (a == `SPTS_OFF_RX_LIM)
         rd_mux = {16'h0000, rx_lim};
      else if (a == `SPTS_OFF_RX_LIST)
         rd_mux = {30'h00000000, rx_list};
      else if (a == `SPTS_OFF_TX_PTR)
         rd_mux = tx_ptr;
      else if (a == `SPTS_OFF_TX_LIM)
         rd_mux = {16'h0000, tx_lim};
      else if (a == `SPTS_OFF_TX_CNT)
         rd_mux = {16'h0000, tx_amt}; // RULE_04
      else if (a == `SPTS_OFF_TX_LIST)
         rd_mux = {30'h00000000, tx_list};
      else if (a == `SPTS_OFF_CONFIG)
         rd_mux = {29'h00000000, cfg};
      else if (a == `SPTS_OFF_DEF_CHAR)
         rd_mux = {24'h000000, def_char};
      else if (a == `SPTS_OFF_ORC_CHAR)
         rd_mux = {24'h000000, orc_char};
      else
         map_hit = 1'b0;
   end
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
         irq_o <= 1'b0;
         pub_end_o <= '0;
         pub_rxfull_o <= '0;
         pub_acq_o <= '0;
      end
      else
      begin
         pready_o <= acc;
         pslverr_o <= acc & ~map_hit;
         prdata_o <= (acc & ~pwrite_i) ? rd_mux : 32'h00000000;
         irq_o <= |(ev & inten);
         pub_end_o <= {end_now & end_pub.en, end_pub.chan}; // RULE_08
         pub_rxfull_o <= {rx_full_now & rxf_pub.en, rxf_pub.chan}; // RULE_08
         pub_acq_o <= {acq_ev_now & acq_pub.en, acq_pub.chan}; // RULE_08
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_cpu_release;
      (sem == SPTS_SEM_CPU) && rel_task && enable_q && enable;
   endsequence
   chk_release_frees_sem: assert property (s_cpu_release |=> sem == SPTS_SEM_FREE) // RULE_01
      else $error("release did not free semaphore");
   chk_ignored_sends_def: assert property (cs_fall && !grant_now |=> ignored && tx_sh == $past(def_char)) // RULE_02
      else $error("ignored transfer lacks default char");
   chk_rx_amount_update: assert property (end_now |=> rx_amt == $past(rx_cnt) && tx_amt == $past(tx_cnt)) // RULE_03
      else $error("byte counts not captured at end");
   chk_rx_limit_kept: assert property (active && granted |-> rx_cnt <= rx_lim) // RULE_05
      else $error("receive count past limit");
   chk_sub_acq_task: assert property (sub_acq && enable |-> acq_task) // RULE_07
      else $error("subscribed acquire not triggered");
   chk_end_publish: assert property (end_now && end_pub.en |=> pub_end_o.valid ##1 !pub_end_o.valid) // RULE_08
      else $error("end event not published once");
   chk_enable_silent: assert property ($rose(enable) |=> sem == SPTS_SEM_CPU && !pub_acq_o.valid) // RULE_11
      else $error("enable handover wrong");
   sequence s_tie;
      cs_fall && acq_task && sem == SPTS_SEM_FREE && enable_q;
   endsequence
   chk_tie_to_cpu: assert property (s_tie |=> sem == SPTS_SEM_CPU && ignored) // RULE_12
      else $error("tie not granted to CPU");
   chk_pending_served: assert property (sem == SPTS_SEM_TGT_PEND && end_now && enable |=> sem == SPTS_SEM_CPU ##1 ev[2]) // RULE_13
      else $error("pending acquire not served");
   chk_overflow_flag: assert property (ovf_now |=> status[`SPTS_ST_OVERFLOW_BIT] && !rx_wr_o) // RULE_14
      else $error("overflow not flagged");
   chk_status_sticky: assert property (status[0] && !(wr && a == `SPTS_OFF_STATUS) |=> status[0]) // RULE_10
      else $error("status bit lost");
   chk_acq_reads_zero: assert property (fire && !pwrite_i |-> prdata_o == 32'h0 || $past(a) != `SPTS_OFF_ACQ_TASK) // RULE_15
      else $error("acquire task read nonzero");
endmodule : spts_top
`default_nettype wire

/* File: spts_spi_ctrl.sv */
// Behavioural SPI controller driving select, clock and data into the target
`timescale 1ns/1ps
`default_nettype none
module spts_spi_ctrl (
   input wire logic clk_i,
   input wire logic miso_i,
   output logic sck_o,
   output logic cs_b_o,
   output logic mosi_o
);
   initial
   begin
      sck_o = 1'b0;
      cs_b_o = 1'b1;
      mosi_o = 1'b1;
   end
   // Mode 0, MSB first, 4 clocks a half period gives a 320 ns link clock
   task frame(input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_i);
      cs_b_o <= 1'b0;
      repeat (16) @(posedge clk_i);
      for (int i = 15; i >= 0; i--)
      begin
         mosi_o <= d[i];
         repeat (4) @(posedge clk_i);
         sck_o <= 1'b1;
         q[i] = miso_i;
         repeat (4) @(posedge clk_i);
         sck_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      cs_b_o <= 1'b1;
      // Released data line flips so a stale level never looks valid
      mosi_o <= ~d[0];
      repeat (12) @(posedge clk_i);
   endtask : frame
endmodule : spts_spi_ctrl
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the SPI target semaphore register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
   import spts_pkg::*;
   logic clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0, perr, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r, rx_addr, rx_addr_q, tx_addr;
   logic sck, cs_b, mosi, miso, miso_oe, rx_wr, irq;
   logic [7:0] rx_data, rx_data_q, tx_data;
   logic [15:0] q;
   spts_evch_t sub = '0, pub_end, pub_rx, pub_acq;
   int n_errors = 0, checked = 0, cyc = 0, n_wr = 0, n_end = 0, n_acq = 0, n_rxf = 0;
   localparam logic [11:0] RA [9] = '{12'h534, 12'h544, 12'h538, 12'h548, 12'h184,
      12'h0a8, 12'h200, 12'h1a8, 12'h190};
   localparam logic [31:0] RV [9] = '{32'h20000100, 32'h20000200, 32'h1, 32'h1,
      32'h80000003, 32'h80000005, 32'h4, 32'h80000009, 32'h8000000b};
   initial forever #20 clk_i = ~clk_i;
   // Buffer memory answers in the same cycle, contents derived from the address
   assign tx_data = tx_addr[7:0] ^ 8'h3c;
   spts_top spts_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sck_i(sck), .cs_b_i(cs_b), .mosi_i(mosi),
      .miso_o(miso), .miso_oe_o(miso_oe), .rx_wr_o(rx_wr), .rx_wr_addr_o(rx_addr),
      .rx_wr_data_o(rx_data), .tx_rd_addr_o(tx_addr), .tx_rd_data_i(tx_data), .sub_i(sub),
      .pub_end_o(pub_end), .pub_rxfull_o(pub_rx), .pub_acq_o(pub_acq), .irq_o(irq));
   spts_spi_ctrl spts_spi_ctrl_i (.clk_i(clk_i), .miso_i(miso), .sck_o(sck), .cs_b_o(cs_b),
      .mosi_o(mosi));
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (rx_wr === 1'b1)
      begin
         n_wr <= n_wr + 1;
         rx_data_q <= rx_data;
         rx_addr_q <= rx_addr;
      end
      if (pub_end.valid === 1'b1 && pub_end.chan === 8'h03)
         n_end <= n_end + 1;
      if (pub_acq.valid === 1'b1 && pub_acq.chan === 8'h09)
         n_acq <= n_acq + 1;
      if (pub_rx.valid === 1'b1 && pub_rx.chan === 8'h0b)
         n_rxf <= n_rxf + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   task report_and_stop;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   // Entered just after a rising edge; holds the request until pready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      // Ends on pready high; only the bench timeout ends a wait that never sees it
      while (pready !== 1'b1)
         @(posedge clk_i);
      r = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task ck(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(r, e)
   endtask : ck
   task t_regs;
      for (int i = 0; i < 9; i++)
      begin
         apb(1'b1, RA[i], RV[i]);
         ck(RA[i], RV[i]);
      end
      ck(12'h024, 32'h0);
      ck(12'h7fc, 32'h0);
      `CHK(perr, 1'b1)
      apb(1'b1, 12'h55c, 32'h5a);
      apb(1'b1, 12'h5c0, 32'h99);
      ck(12'h55c, 32'h5a);
      $display("test regs done");
   endtask : t_regs
   task t_ignored;
      apb(1'b1, 12'h500, 32'h2);
      ck(12'h400, 32'h2);
      ck(12'h128, 32'h0);
      spts_spi_ctrl_i.frame(16'h1234, q);
      `CHK(q, 16'h5a5a)
      `CHK(n_wr, 0)
      `CHK(n_acq, 0)
      $display("test ignored done");
   endtask : t_ignored
   task t_granted;
      sub <= '{1'b1, 8'h05};
      @(posedge clk_i);
      sub <= '0;
      @(posedge clk_i);
      ck(12'h400, 32'h1);
      spts_spi_ctrl_i.frame(16'hc37e, q);
      `CHK(q, 16'h3c99)
      `CHK(n_wr, 1)
      `CHK(rx_data_q, 8'hc3)
      `CHK(rx_addr_q, 32'h20000100)
      ck(12'h530, 32'h1);
      ck(12'h54c, 32'h1);
      ck(12'h440, 32'h3);
      ck(12'h104, 32'h1);
      `CHK(n_end, 1)
      `CHK(n_acq, 1)
      `CHK(n_rxf, 1)
      ck(12'h400, 32'h2);
      ck(12'h128, 32'h1);
      $display("test granted done");
   endtask : t_granted
   task t_acquire;
      apb(1'b1, 12'h200, 32'h0);
      apb(1'b1, 12'h304, 32'h400);
      ck(12'h128, 32'h1);
      `CHK(irq, 1'b1)
      apb(1'b1, 12'h128, 32'h1);
      ck(12'h128, 32'h0);
      `CHK(irq, 1'b0)
      apb(1'b1, 12'h024, 32'h1);
      ck(12'h128, 32'h1);
      `CHK(irq, 1'b1)
      apb(1'b1, 12'h028, 32'h1);
      ck(12'h400, 32'h1);
      // Subscribed acquire lands on the same edge as the select fall
      apb(1'b1, 12'h128, 32'h1);
      apb(1'b1, 12'h0a4, 32'h80000007);
      fork
         spts_spi_ctrl_i.frame(16'h0ff0, q);
         begin
            repeat (3) @(posedge clk_i);
            sub <= '{1'b1, 8'h07};
            @(posedge clk_i);
            sub <= '0;
            @(posedge clk_i);
            `CHK(miso_oe, 1'b1)
         end
      join
      `CHK(miso_oe, 1'b0)
      `CHK(q, 16'h5a5a)
      `CHK(n_wr, 1)
      `CHK(n_acq, 3)
      ck(12'h400, 32'h2);
      ck(12'h128, 32'h1);
      $display("test acquire done");
   endtask : t_acquire
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_ignored();
      t_granted();
      t_acquire();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
